/* common/pldc_pkg.sv */
// Purpose: shared constants for the indicator and digital configuration block
// Assumes: 100 MHz internal clock, 16-bit management registers
// Notes:   every offset, reset value and cycle count lives here
package pldc_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned NS_PER_MS      = 1000000;

    // management register addresses
    localparam logic [4:0]  IND_CFG_ADDR   = 5'h14;
    localparam logic [4:0]  DIG_CFG_ADDR   = 5'h1A;

    // reset values
    localparam logic [15:0] IND_CFG_RESET  = 16'h0022;
    localparam logic [15:0] DIG_CFG_RESET  = 16'h0000;

    // indicator configuration field positions
    localparam int unsigned SRC_LSB        = 4;
    localparam int unsigned PERIOD_LSB     = 2;
    localparam int unsigned STRETCH_EN_BIT = 1;

    // digital configuration field positions
    localparam int unsigned DRIVE_BIT      = 11;
    localparam int unsigned SYMERR_BIT     = 9;

    // field reset values
    localparam logic [3:0]  SRC_RESET      = 4'h2;
    localparam logic [1:0]  PERIOD_RESET   = 2'h0;
    localparam logic        STRETCH_RESET  = 1'b1;

    // stretch periods
    localparam int unsigned STRETCH_30_MS  = 30;
    localparam int unsigned STRETCH_60_MS  = 60;
    localparam int unsigned STRETCH_100_MS = 100;
    localparam int unsigned STRETCH_30_CYC  = STRETCH_30_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned STRETCH_60_CYC  = STRETCH_60_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned STRETCH_100_CYC = STRETCH_100_MS * (NS_PER_MS / CLK_PERIOD_NS);

    // test-mode blink half periods
    localparam int unsigned BLINK_FAST_MS  = 100;
    localparam int unsigned BLINK_SLOW_MS  = 500;
    localparam int unsigned BLINK_FAST_CYC = BLINK_FAST_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned BLINK_SLOW_CYC = BLINK_SLOW_MS * (NS_PER_MS / CLK_PERIOD_NS);

    // counter widths
    localparam int unsigned STRETCH_CW     = 24;
    localparam int unsigned BLINK_CW       = 27;

    // management frame
    localparam int unsigned PREAMBLE_BITS  = 32;
    localparam int unsigned HEADER_BITS    = 13;
    localparam int unsigned DATA_BITS      = 16;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;

    // stretch period codes
    localparam logic [1:0]  PERIOD_30      = 2'h0;
    localparam logic [1:0]  PERIOD_60      = 2'h1;

    // indicator source codes
    typedef enum logic [3:0] {
        SRC_SPEED      = 4'h0,
        SRC_TX         = 4'h1,
        SRC_RX         = 4'h2,
        SRC_COL        = 4'h3,
        SRC_LINK       = 4'h4,
        SRC_DUPLEX     = 4'h5,
        SRC_UNUSED6    = 4'h6,
        SRC_ACT        = 4'h7,
        SRC_ON         = 4'h8,
        SRC_OFF        = 4'h9,
        SRC_BLINK_FAST = 4'hA,
        SRC_BLINK_SLOW = 4'hB,
        SRC_LINK_RX    = 4'hC,
        SRC_LINK_ACT   = 4'hD,
        SRC_DPX_COL    = 4'hE,
        SRC_UNUSEDF    = 4'hF
    } pldc_src_type;

endpackage : pldc_pkg

/* verilog/pldc_stretch.sv */
// Purpose: retriggerable pulse stretcher for one indicator event
// Assumes: event_i comes from logic on the same clock
// Notes:   a new event reloads the timer, so bursts stay lit as one pulse
`timescale 1ns/1ps
module pldc_stretch #(
    parameter int unsigned CW = pldc_pkg::STRETCH_CW
) (
    input  wire logic          ref_clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          event_i,
    input  wire logic [CW-1:0] load_i,
    output logic               active_o
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          active_q;
    logic          active_d;

    // reload on every event, otherwise count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (event_i) begin
            cnt_d = load_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end
        active_d = event_i | (cnt_d != '0);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            active_q <= active_d;
        end
    end

    assign active_o = active_q;

endmodule : pldc_stretch

/* verilog/pldc_top.sv */
// Purpose: indicator and digital configuration registers behind the management port, third indicator driver
// Assumes: status inputs come from the datapath on ref_clk_i; mdc/mdio and the address strap are pins
// Notes:   management clock is oversampled, so it must stay well below ref_clk_i / 4
`timescale 1ns/1ps
module pldc_top #(
    parameter int unsigned STRETCH_30_CYC  = pldc_pkg::STRETCH_30_CYC,
    parameter int unsigned STRETCH_60_CYC  = pldc_pkg::STRETCH_60_CYC,
    parameter int unsigned STRETCH_100_CYC = pldc_pkg::STRETCH_100_CYC,
    parameter int unsigned BLINK_FAST_CYC  = pldc_pkg::BLINK_FAST_CYC,
    parameter int unsigned BLINK_SLOW_CYC  = pldc_pkg::BLINK_SLOW_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [4:0] phy_addr_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_n_o,
    input  wire logic       link_up_i,
    input  wire logic       full_duplex_i,
    input  wire logic       speed_100_i,
    input  wire logic       tx_event_i,
    input  wire logic       rx_event_i,
    input  wire logic       col_event_i,
    input  wire logic       rx_err_i,
    input  wire logic       symbol_err_i,
    output logic            mii_rx_err_o,
    output logic            mii_drive_high_o,
    output logic            third_indicator_o
);

    localparam int unsigned SCW = pldc_pkg::STRETCH_CW;
    localparam int unsigned BCW = pldc_pkg::BLINK_CW;

    // refuse zero counts, and longest-stretch and blink counts that the counters cannot hold
    if (STRETCH_30_CYC < 1 || STRETCH_60_CYC < 1 || STRETCH_100_CYC < 1 ||
        STRETCH_100_CYC >= (1 << SCW) || BLINK_FAST_CYC < 1 || BLINK_SLOW_CYC < 1 ||
        BLINK_FAST_CYC >= (1 << BCW) || BLINK_SLOW_CYC >= (1 << BCW)) begin : g_bad
        $error("pldc_top: cycle count parameter out of range");
    end

    typedef enum logic [3:0] {
        ST_PRE  = 4'h1,
        ST_HDR  = 4'h2,
        ST_TA   = 4'h4,
        ST_DATA = 4'h8
    } pldc_state_type;

    // pin synchronisers; the first stage feeds only the second
    logic       mdc_m_q, mdc_s_q, mdc_p_q, mdio_m_q, mdio_s_q;
    logic [4:0] addr_m_q, addr_s_q;
    logic       mdc_rise;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            mdc_m_q  <= 1'b0;
            mdc_s_q  <= 1'b0;
            mdc_p_q  <= 1'b0;
            mdio_m_q <= 1'b1;
            mdio_s_q <= 1'b1;
            addr_m_q <= 5'h00;
            addr_s_q <= 5'h00;
        end else begin
            mdc_m_q  <= mdc_i;
            mdc_s_q  <= mdc_m_q;
            mdc_p_q  <= mdc_s_q;
            mdio_m_q <= mdio_i;
            mdio_s_q <= mdio_m_q;
            addr_m_q <= phy_addr_i;
            addr_s_q <= addr_m_q;
        end
    end

    assign mdc_rise = mdc_s_q & ~mdc_p_q;

    // configuration registers
    logic [3:0]  src_q, src_d;
    logic [1:0]  period_q, period_d;
    logic        stretch_en_q, stretch_en_d;
    logic        drive_q, drive_d;
    logic        symerr_q, symerr_d;
    logic        wr_ind, wr_dig;
    logic [15:0] wr_data;
    logic [15:0] ind_rd, dig_rd;

    // reserved bits and the untouched upper indicator fields read as zero
    always_comb begin
        ind_rd = 16'h0000;
        ind_rd[pldc_pkg::SRC_LSB +: 4]     = src_q;
        ind_rd[pldc_pkg::PERIOD_LSB +: 2]  = period_q;
        ind_rd[pldc_pkg::STRETCH_EN_BIT]   = stretch_en_q;
        dig_rd = 16'h0000;
        dig_rd[pldc_pkg::DRIVE_BIT]        = drive_q;
        dig_rd[pldc_pkg::SYMERR_BIT]       = symerr_q;
    end

    // only defined fields are stored; reserved write bits are dropped
    always_comb begin
        src_d        = src_q;
        period_d     = period_q;
        stretch_en_d = stretch_en_q;
        drive_d      = drive_q;
        symerr_d     = symerr_q;
        if (wr_ind) begin
            src_d        = wr_data[pldc_pkg::SRC_LSB +: 4];
            period_d     = wr_data[pldc_pkg::PERIOD_LSB +: 2];
            stretch_en_d = wr_data[pldc_pkg::STRETCH_EN_BIT];
        end
        if (wr_dig) begin
            drive_d      = wr_data[pldc_pkg::DRIVE_BIT];
            symerr_d     = wr_data[pldc_pkg::SYMERR_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            src_q        <= pldc_pkg::SRC_RESET;
            period_q     <= pldc_pkg::PERIOD_RESET;
            stretch_en_q <= pldc_pkg::STRETCH_RESET;
            drive_q      <= 1'b0;
            symerr_q     <= 1'b0;
        end else begin
            src_q        <= src_d;
            period_q     <= period_d;
            stretch_en_q <= stretch_en_d;
            drive_q      <= drive_d;
            symerr_q     <= symerr_d;
        end
    end

    // management frame engine
    pldc_state_type st_q, st_d;
    logic [5:0]     cnt_q, cnt_d;
    logic [15:0]    sh_q, sh_d;
    logic           rd_q, rd_d, sel_dig_q, sel_dig_d;
    logic           out_q, out_d, drv_q, drv_d;
    logic [12:0]    hdr;
    logic           hdr_ok;

    assign hdr    = {sh_q[11:0], mdio_s_q};
    assign hdr_ok = hdr[12] && (hdr[9:5] == addr_s_q) &&
                    (hdr[4:0] == pldc_pkg::IND_CFG_ADDR || hdr[4:0] == pldc_pkg::DIG_CFG_ADDR) &&
                    (hdr[11:10] == pldc_pkg::OP_READ || hdr[11:10] == pldc_pkg::OP_WRITE);

    // frames for other addresses or registers are left alone, the pin stays released
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        rd_d      = rd_q;
        sel_dig_d = sel_dig_q;
        out_d     = out_q;
        drv_d     = drv_q;
        wr_ind    = 1'b0;
        wr_dig    = 1'b0;
        wr_data   = {sh_q[14:0], mdio_s_q};
        if (mdc_rise) begin
            unique case (st_q)
                ST_PRE: begin
                    if (mdio_s_q) begin
                        if (cnt_q != 6'(pldc_pkg::PREAMBLE_BITS)) cnt_d = cnt_q + 6'h01;
                    end else if (cnt_q == 6'(pldc_pkg::PREAMBLE_BITS)) begin
                        st_d  = ST_HDR;
                        cnt_d = 6'h00;
                    end else begin
                        cnt_d = 6'h00;
                    end
                end
                ST_HDR: begin
                    sh_d  = {sh_q[14:0], mdio_s_q};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == 6'(pldc_pkg::HEADER_BITS - 1)) begin
                        cnt_d     = 6'h00;
                        st_d      = hdr_ok ? ST_TA : ST_PRE;
                        rd_d      = (hdr[11:10] == pldc_pkg::OP_READ);
                        sel_dig_d = (hdr[4:0] == pldc_pkg::DIG_CFG_ADDR);
                        sh_d      = (hdr[4:0] == pldc_pkg::DIG_CFG_ADDR) ? dig_rd : ind_rd;
                    end
                end
                ST_TA: begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == 6'h00) begin
                        drv_d = rd_q;          // drive the turnaround zero on reads
                        out_d = 1'b0;
                    end else begin
                        st_d  = ST_DATA;
                        cnt_d = 6'h00;
                        out_d = sh_q[15];
                        if (rd_q) sh_d = {sh_q[14:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    cnt_d = cnt_q + 6'h01;
                    if (rd_q) begin
                        out_d = sh_q[15];
                        sh_d  = {sh_q[14:0], 1'b0};
                    end else begin
                        sh_d  = {sh_q[14:0], mdio_s_q};
                    end
                    if (cnt_q == 6'(pldc_pkg::DATA_BITS - 1)) begin
                        st_d   = ST_PRE;
                        cnt_d  = 6'h00;
                        drv_d  = 1'b0;
                        wr_ind = !rd_q && !sel_dig_q;
                        wr_dig = !rd_q && sel_dig_q;
                    end
                end
                default: begin
                    st_d  = ST_PRE;
                    cnt_d = 6'h00;
                    drv_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            st_q      <= ST_PRE;
            cnt_q     <= 6'h00;
            sh_q      <= 16'h0000;
            rd_q      <= 1'b0;
            sel_dig_q <= 1'b0;
            out_q     <= 1'b1;
            drv_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            sh_q      <= sh_d;
            rd_q      <= rd_d;
            sel_dig_q <= sel_dig_d;
            out_q     <= out_d;
            drv_q     <= drv_d;
        end
    end

    assign mdio_o      = out_q;
    assign mdio_oe_n_o = ~drv_q;

    // stretch period select; the reserved code falls back to the longest period
    logic [SCW-1:0] period_cyc;
    always_comb begin
        unique case (period_q)
            pldc_pkg::PERIOD_30: period_cyc = SCW'(STRETCH_30_CYC);
            pldc_pkg::PERIOD_60: period_cyc = SCW'(STRETCH_60_CYC);
            default:             period_cyc = SCW'(STRETCH_100_CYC);
        endcase
    end

    // one stretcher per event: tx, rx, collision, activity
    logic [3:0] ev_raw, ev_str;
    assign ev_raw = {tx_event_i | rx_event_i, col_event_i, rx_event_i, tx_event_i};

    for (genvar g = 0; g < 4; g++) begin : g_str
        pldc_stretch #(
            .CW       (SCW)
        ) u_str (
            .ref_clk_i(ref_clk_i),
            .reset_n_i(reset_n_i),
            .event_i  (ev_raw[g]),
            .load_i   (period_cyc),
            .active_o (ev_str[g])
        );
    end

    // test-mode blink generators
    logic [BCW-1:0] fast_cnt_q, fast_cnt_d, slow_cnt_q, slow_cnt_d;
    logic           fast_q, fast_d, slow_q, slow_d;

    always_comb begin
        fast_cnt_d = fast_cnt_q + BCW'(1);
        fast_d     = fast_q;
        if (fast_cnt_q == BCW'(BLINK_FAST_CYC - 1)) begin
            fast_cnt_d = '0;
            fast_d     = ~fast_q;
        end
        slow_cnt_d = slow_cnt_q + BCW'(1);
        slow_d     = slow_q;
        if (slow_cnt_q == BCW'(BLINK_SLOW_CYC - 1)) begin
            slow_cnt_d = '0;
            slow_d     = ~slow_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            fast_cnt_q <= '0;
            slow_cnt_q <= '0;
            fast_q     <= 1'b0;
            slow_q     <= 1'b0;
        end else begin
            fast_cnt_q <= fast_cnt_d;
            slow_cnt_q <= slow_cnt_d;
            fast_q     <= fast_d;
            slow_q     <= slow_d;
        end
    end

    // indicator select and output registers
    logic [3:0] ev_sel;
    logic       led_d, led_q, rxer_d, rxer_q;

    always_comb begin
        ev_sel = stretch_en_q ? ev_str : ev_raw;
        unique case (pldc_pkg::pldc_src_type'(src_q))
            pldc_pkg::SRC_SPEED:      led_d = speed_100_i;
            pldc_pkg::SRC_TX:         led_d = ev_sel[0];
            pldc_pkg::SRC_RX:         led_d = ev_sel[1];
            pldc_pkg::SRC_COL:        led_d = ev_sel[2];
            pldc_pkg::SRC_LINK:       led_d = link_up_i;
            pldc_pkg::SRC_DUPLEX:     led_d = full_duplex_i;
            pldc_pkg::SRC_ACT:        led_d = ev_sel[3];
            pldc_pkg::SRC_ON:         led_d = 1'b1;
            pldc_pkg::SRC_BLINK_FAST: led_d = fast_q;
            pldc_pkg::SRC_BLINK_SLOW: led_d = slow_q;
            pldc_pkg::SRC_LINK_RX:    led_d = link_up_i ^ ev_str[1];
            pldc_pkg::SRC_LINK_ACT:   led_d = link_up_i ^ ev_str[3];
            pldc_pkg::SRC_DPX_COL:    led_d = full_duplex_i ^ ev_str[2];
            default:                  led_d = 1'b0;              // off, unused codes
        endcase
        rxer_d = symerr_q ? symbol_err_i : rx_err_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            led_q  <= 1'b0;
            rxer_q <= 1'b0;
        end else begin
            led_q  <= led_d;
            rxer_q <= rxer_d;
        end
    end

    assign third_indicator_o = led_q;
    assign mii_rx_err_o      = rxer_q;
    assign mii_drive_high_o  = drive_q;

endmodule : pldc_top

/* tb/pldc_chk.sv */
// Purpose: port-level checks of the indicator and digital configuration block
// Assumes: bound into pldc_top, one clock domain
// Notes:   power-up mode checks hold only until the first mdc edge
`timescale 1ns/1ps
module pldc_chk #(
    parameter int unsigned STRETCH_30_CYC = 20
) (
    input wire logic       ref_clk_i,
    input wire logic       reset_n_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic       mdc_i,
    input wire logic       mdio_i,
    input wire logic       mdio_o,
    input wire logic       mdio_oe_n_o,
    input wire logic       link_up_i,
    input wire logic       full_duplex_i,
    input wire logic       speed_100_i,
    input wire logic       tx_event_i,
    input wire logic       rx_event_i,
    input wire logic       col_event_i,
    input wire logic       rx_err_i,
    input wire logic       symbol_err_i,
    input wire logic       mii_rx_err_o,
    input wire logic       mii_drive_high_o,
    input wire logic       third_indicator_o
);
    logic        dflt_q;
    logic        seen_q;
    int unsigned idle_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    // power-up config flag and cycles since the last receive event
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            dflt_q <= 1'b1;
            seen_q <= 1'b0;
            idle_q <= 0;
        end else begin
            if (mdc_i) dflt_q <= 1'b0; // any frame may change the config
            if (rx_event_i) begin
                seen_q <= 1'b1;
                idle_q <= 0;
            end else if (idle_q < 1000) idle_q <= idle_q + 1; // saturate, no wrap
        end
    end
    AST_RESET_OUTS: assert property (!reset_n_i |=> !third_indicator_o && mdio_oe_n_o && mdio_o
        && !mii_drive_high_o && !mii_rx_err_o) else $error("outputs not at reset level");
    AST_RXERR_SAME: assert property (disable iff (!reset_n_i)
        rx_err_i == symbol_err_i |=> mii_rx_err_o == $past(rx_err_i)) else $error("receive error lost");
    AST_DEF_RX_ON: assert property (disable iff (!reset_n_i) dflt_q && rx_event_i |-> ##2 third_indicator_o)
        else $error("receive event not shown");
    AST_DEF_HOLD: assert property (disable iff (!reset_n_i)
        dflt_q && seen_q && idle_q >= 2 && idle_q < STRETCH_30_CYC |-> third_indicator_o)
        else $error("stretch ended early");
    AST_DEF_END: assert property (disable iff (!reset_n_i)
        dflt_q && idle_q >= STRETCH_30_CYC + 3 |-> !third_indicator_o) else $error("stretch too long");
    AST_OE_FALL: assert property (disable iff (!reset_n_i)
        $fell(mdio_oe_n_o) |-> !mdio_o && $past(mdc_i, 2)) else $error("turnaround drive wrong");
    AST_MDIO_QUIET: assert property (disable iff (!reset_n_i)
        $stable(mdc_i) [*8] |-> $stable(mdio_oe_n_o) && $stable(mdio_o)) else $error("mdio moved while idle");
    AST_DRIVE_CAUSE: assert property (disable iff (!reset_n_i)
        $changed(mii_drive_high_o) |-> $past(mdc_i, 3)) else $error("drive changed without a frame");
endmodule : pldc_chk
bind pldc_top pldc_chk #(.STRETCH_30_CYC(STRETCH_30_CYC)) chk_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .phy_addr_i(phy_addr_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
    .link_up_i(link_up_i), .full_duplex_i(full_duplex_i), .speed_100_i(speed_100_i), .tx_event_i(tx_event_i),
    .rx_event_i(rx_event_i), .col_event_i(col_event_i), .rx_err_i(rx_err_i), .symbol_err_i(symbol_err_i),
    .mii_rx_err_o(mii_rx_err_o), .mii_drive_high_o(mii_drive_high_o), .third_indicator_o(third_indicator_o));

/* tb/pldc_station.sv */
// Purpose: station management model sending whole frames on mdc and mdio
// Assumes: the bench resolves the shared wire with a pull-up
// Notes:   mdc stands low between frames; half period of 5 clocks
`timescale 1ns/1ps
module pldc_station (
    input  wire logic ref_clk_i,
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_en_o
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_en_o = 1'b0;
    end
    // one frame; a read releases the wire from the turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        wd = (ra == pldc_pkg::IND_CFG_ADDR) ? wd & 16'h00FE : wd & 16'h0A00;
        bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        @(posedge ref_clk_i);
        for (int i = 63; i >= 0; i--) begin
            mdio_en_o <= !(op == pldc_pkg::OP_READ && i < 18);
            mdio_o <= bits[i];
            repeat (5) @(posedge ref_clk_i);
            if (i < 16) rd[i] = mdio_i; // read bit taken at the mdc rise
            mdc_o <= 1'b1;
            repeat (5) @(posedge ref_clk_i);
            mdc_o <= 1'b0;
        end
        mdio_en_o <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask : frame
endmodule : pldc_station

/* tb/pldc_top_tb.sv */
// Purpose: self-checking bench for the indicator and digital configuration block
// Assumes: short stretch counts 20/40/60, mdc at a tenth of the clock
// Notes:   register model keeps only the bits the block implements
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module pldc_top_tb;
    localparam int unsigned P [3] = '{20, 40, 60};
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        link_up_i = 1'b0;
    logic        full_dpx  = 1'b0;
    logic [2:0]  ev_q      = 3'h0; // tx, rx, col
    logic        rx_err    = 1'b0;
    logic        sym_err   = 1'b0;
    logic        speed     = 1'b0;
    logic [4:0]  strap     = 5'h05; // randomised at reset release
    logic        mdc, stn_d, stn_en, dut_d, dut_oe_n, mdio_w, drive_hi, rx_err_o, led;
    logic [15:0] rd;
    logic [15:0] ind_m     = 16'h0022; // source 0010, period 00, stretch on
    logic [15:0] dig_m     = 16'h0000;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          seed       = 66;
    always #5 ref_clk_i = ~ref_clk_i;
    // shared wire: device first, then station, else the pull-up
    assign mdio_w = !dut_oe_n ? dut_d : (stn_en ? stn_d : 1'b1);
    pldc_top #(.STRETCH_30_CYC(20), .STRETCH_60_CYC(40), .STRETCH_100_CYC(60), .BLINK_FAST_CYC(8),
               .BLINK_SLOW_CYC(16)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .phy_addr_i(strap), .mdc_i(mdc), .mdio_i(mdio_w),
        .mdio_o(dut_d), .mdio_oe_n_o(dut_oe_n), .link_up_i(link_up_i), .full_duplex_i(full_dpx),
        .speed_100_i(speed), .tx_event_i(ev_q[2]), .rx_event_i(ev_q[1]), .col_event_i(ev_q[0]),
        .rx_err_i(rx_err), .symbol_err_i(sym_err), .mii_rx_err_o(rx_err_o),
        .mii_drive_high_o(drive_hi), .third_indicator_o(led));
    pldc_station stn_u (.ref_clk_i(ref_clk_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(stn_d), .mdio_en_o(stn_en));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // writes land in the model masked to the implemented bits
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        stn_u.frame(pldc_pkg::OP_WRITE, strap, ra, d, rd);
        if (ra == pldc_pkg::IND_CFG_ADDR) ind_m = d & 16'h00FE;
        else dig_m = d & 16'h0A00;
        repeat (4) @(posedge ref_clk_i);
    endtask : wr
    task automatic rdchk(input logic [4:0] ra);
        stn_u.frame(pldc_pkg::OP_READ, strap, ra, 16'h0000, rd);
        `CHK("readback", (ra == pldc_pkg::IND_CFG_ADDR) ? ind_m : dig_m, rd)
    endtask : rdchk
    // one-cycle pulse, seen by the block at the edge that ends the task
    task automatic ev(input logic [2:0] m);
        @(posedge ref_clk_i);
        ev_q <= m;
        @(posedge ref_clk_i);
        ev_q <= 3'h0;
    endtask : ev
    task automatic chk_led(input int n, input logic ex);
        repeat (n) @(posedge ref_clk_i);
        #1 `CHK("indicator", ex, led)
    endtask : chk_led
    // stretched window: held through the period, back afterwards
    task automatic stretch(input int p, input logic on);
        chk_led(3, on);
        chk_led(p - 3, on);
        chk_led(4, !on);
    endtask : stretch
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        strap     <= 5'($random(seed));
        reset_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        ev(3'h2);
        chk_led(3, 1'b1);
        repeat (10) @(posedge ref_clk_i);
        ev(3'h2);
        stretch(P[0], 1'b1);
        ev(3'h4);
        chk_led(3, 1'b0);
        rdchk(pldc_pkg::IND_CFG_ADDR);
        rdchk(pldc_pkg::DIG_CFG_ADDR);
        stn_u.frame(pldc_pkg::OP_READ, strap ^ 5'h01, pldc_pkg::IND_CFG_ADDR, 16'h0000, rd);
        `CHK("foreign read", 16'hFFFF, rd)
        for (int c = 0; c < 3; c++) begin
            wr(pldc_pkg::IND_CFG_ADDR, {8'h00, 4'h2, c[1:0], 2'b10});
            ev(3'h2);
            stretch(P[c], 1'b1);
        end
        wr(pldc_pkg::IND_CFG_ADDR, 16'h0020);
        ev(3'h2);
        chk_led(3, 1'b0);
        @(posedge ref_clk_i) link_up_i <= 1'b1;
        wr(pldc_pkg::IND_CFG_ADDR, 16'h00C0);
        chk_led(2, 1'b1);
        ev(3'h2);
        stretch(P[0], 1'b0);
        @(posedge ref_clk_i) link_up_i <= 1'b0;
        wr(pldc_pkg::IND_CFG_ADDR, 16'h00D0);
        chk_led(2, 1'b0);
        ev(3'h4);
        stretch(P[0], 1'b1);
        @(posedge ref_clk_i) full_dpx <= 1'b1;
        wr(pldc_pkg::IND_CFG_ADDR, 16'h00E0);
        chk_led(2, 1'b1);
        ev(3'h1);
        stretch(P[0], 1'b0);
        // speed source follows its input; a blink level is inverted one half period later
        wr(pldc_pkg::IND_CFG_ADDR, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk_i) speed <= !s[0];
            chk_led(2, !s[0]);
        end
        for (int b = 0; b < 2; b++) begin
            wr(pldc_pkg::IND_CFG_ADDR, {8'h00, 3'h5, b[0], 4'h0});
            #1 chk_led(8 << b, !led);
        end
        // random register traffic, alternating the two registers
        for (int k = 0; k < 4; k++) begin
            wr(k[0] ? pldc_pkg::DIG_CFG_ADDR : pldc_pkg::IND_CFG_ADDR, 16'($random(seed)));
            rdchk(k[0] ? pldc_pkg::DIG_CFG_ADDR : pldc_pkg::IND_CFG_ADDR);
        end
        for (int s = 0; s < 2; s++) begin
            wr(pldc_pkg::DIG_CFG_ADDR, s[0] ? 16'h0A00 : 16'h0000);
            `CHK("drive", dig_m[11], drive_hi)
            repeat (8) begin
                @(posedge ref_clk_i);
                {rx_err, sym_err} <= 2'($random(seed));
                @(posedge ref_clk_i);
                #1 `CHK("rx error", dig_m[9] ? sym_err : rx_err, rx_err_o)
            end
        end
        end_of_test();
    end
endmodule : pldc_top_tb
